// file: amc_pkg.sv
// Purpose: constants and types for the converter mode control block
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register
// Notes: byte offsets decoded from haddr[7:0] only
package amc_pkg;
  localparam logic [7:0] OFS_MODE0   = 8'h00;
  localparam logic [7:0] OFS_MODE1   = 8'h04;
  localparam logic [7:0] OFS_MODE2   = 8'h08;
  localparam logic [7:0] OFS_UPPER   = 8'h0C;
  localparam logic [7:0] OFS_LOWER   = 8'h10;
  localparam logic [7:0] OFS_CHAN    = 8'h14;
  localparam logic [7:0] OFS_RESULT  = 8'h18;
  localparam logic [7:0] OFS_IRQMASK = 8'h1C;
  localparam logic [7:0] OFS_IRQFLAG = 8'h20;
  localparam logic [7:0] OFS_PRIOHI  = 8'h24;
  localparam logic [7:0] OFS_PRIOLO  = 8'h28;
  localparam logic [7:0] OFS_PORTDIR = 8'h2C;
  localparam logic [7:0] OFS_EVSTAT  = 8'h30;
  localparam logic [7:0] OFS_EVMASK  = 8'h34;

  localparam logic [7:0] RST_MODE    = 8'h00;
  localparam logic [7:0] RST_UPPER   = 8'hFF;
  localparam logic [7:0] RST_LOWER   = 8'h00;
  localparam logic [7:0] RST_PORTDIR = 8'hFF;
  localparam logic [2:0] RST_EVMASK  = 3'h7;
  localparam logic [7:0] WMASK_MODE1 = 8'hE3;
  localparam logic [7:0] WMASK_MODE2 = 8'hED;
  localparam logic [7:0] WMASK_CHAN  = 8'h9F;

  localparam int RUN_BIT      = 7;
  localparam int EV_END       = 0;
  localparam int EV_REQ       = 1;
  localparam int EV_ERR       = 2;
  localparam int CONV_TICKS_N1 = 19;
  localparam int CONV_TICKS_N2 = 17;
  localparam int STAB_TICKS    = 8;

  localparam logic [1:0] REF_INTERNAL = 2'h2;
  localparam logic [1:0] REF_BAD      = 2'h3;
  localparam logic [1:0] TRIG_HW_WAIT = 2'h3;
  localparam logic [4:0] CH_TEMP      = 5'h00;
  localparam logic [4:0] CH_EXT_LAST0 = 5'h0E;
  localparam logic [4:0] CH_EXT_FIRST1 = 5'h10;
  localparam logic [4:0] CH_EXT_LAST1 = 5'h14;
  localparam logic [4:0] CH_INT_LAST  = 5'h01;

  typedef struct packed {
    logic       run;
    logic       chanScan;
    logic [2:0] divSel;
    logic [1:0] speed;
    logic       compEn;
  } amc_mode0_s;

  typedef struct packed {
    logic [1:0] trigMode;
    logic       oneshot;
    logic [2:0] rsv;
    logic [1:0] trigSrc;
  } amc_mode1_s;

  typedef struct packed {
    logic [1:0] posRef;
    logic       negRef;
    logic       rsv4;
    logic       limitMode;
    logic       awc;
    logic       rsv1;
    logic       res8;
  } amc_mode2_s;

  typedef struct packed {
    logic       compEn;
    logic [1:0] posRef;
    logic       negRef;
    logic       internalSrc;
    logic [4:0] chan;
    logic       res8;
    logic       converting;
  } amc_ana_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_STAB = 2'h1,
    ST_CONV = 2'h3
  } amc_state_e;
endpackage

// file: amc_adc_mode_ctrl.sv
// Purpose: register file and sequencing for the converter mode control
// Assumes: single AHB-Lite master, word accesses, inputs synchronous to clk
// Notes: every access takes one wait state; hresp is always OKAY
`timescale 1ns/1ns
module amc_adc_mode_ctrl #(
  parameter int STAB_TICKS_P = amc_pkg::STAB_TICKS
) (
  input  wire logic           clk,
  input  wire logic           sys_rst,
  input  wire logic           hsel,
  input  wire logic [31:0]    haddr,
  input  wire logic [1:0]     htrans,
  input  wire logic           hwrite,
  input  wire logic [2:0]     hsize,
  input  wire logic [31:0]    hwdata,
  input  wire logic           hready,
  output logic                hreadyout,
  output logic [31:0]         hrdata,
  output logic                hresp,
  input  wire logic           clkGateEn,
  input  wire logic           hwTrigger,
  input  wire logic [9:0]     analogSample,
  output amc_pkg::amc_ana_s   anaCtrl,
  output logic                analogPinOe,
  output logic                convEndIrq,
  output logic [1:0]          irqPrio,
  output logic                irqOut
);
  amc_pkg::amc_mode0_s mode0_ff;
  amc_pkg::amc_mode1_s mode1_ff;
  amc_pkg::amc_mode2_s mode2_ff;
  amc_pkg::amc_state_e state_ff;
  amc_pkg::amc_state_e nxt_state;
  logic [7:0]  upper_ff;
  logic [7:0]  lower_ff;
  logic [7:0]  chan_ff;
  logic [15:0] result_ff;
  logic        irqMask_ff;
  logic        irqFlag_ff;
  logic        prioHi_ff;
  logic        prioLo_ff;
  logic [7:0]  portDir_ff;
  logic [2:0]  evStat_ff;
  logic [2:0]  evMask_ff;
  logic        pend_ff;
  logic        wr_ff;
  logic [7:0]  adr_ff;
  logic [6:0]  divCnt_ff;
  logic        fadTick_ff;
  logic [4:0]  tickCnt_ff;
  logic        trigPend_ff;
  logic [1:0]  scanIdx_ff;

  function automatic logic [6:0] divRatio(input logic [2:0] sel);
    case (sel)
      3'h0:    divRatio = 7'h40;
      3'h1:    divRatio = 7'h20;
      3'h2:    divRatio = 7'h10;
      3'h3:    divRatio = 7'h08;
      3'h4:    divRatio = 7'h06;
      3'h5:    divRatio = 7'h05;
      3'h6:    divRatio = 7'h04;
      default: divRatio = 7'h02;
    endcase
  endfunction

  function automatic logic chanLegal(input logic iss, input logic [4:0] code);
    if (iss) begin
      chanLegal = code <= amc_pkg::CH_INT_LAST;
    end else begin
      chanLegal = code <= amc_pkg::CH_EXT_LAST0 ||
                  (code >= amc_pkg::CH_EXT_FIRST1 && code <= amc_pkg::CH_EXT_LAST1);
    end
  endfunction

  // Bus decode
  wire        addrPh  = hsel & hready & htrans[1];
  wire        access  = pend_ff & clkGateEn;
  wire        wrHit   = access & wr_ff;
  wire [7:0]  wd      = hwdata[7:0];
  wire        wrMode0 = wrHit & (adr_ff == amc_pkg::OFS_MODE0);
  wire        wrMode1 = wrHit & (adr_ff == amc_pkg::OFS_MODE1);
  wire        wrMode2 = wrHit & (adr_ff == amc_pkg::OFS_MODE2);
  wire        wrUpper = wrHit & (adr_ff == amc_pkg::OFS_UPPER);
  wire        wrLower = wrHit & (adr_ff == amc_pkg::OFS_LOWER);
  wire        wrChan  = wrHit & (adr_ff == amc_pkg::OFS_CHAN);
  wire        wrMask  = wrHit & (adr_ff == amc_pkg::OFS_IRQMASK);
  wire        wrFlag  = wrHit & (adr_ff == amc_pkg::OFS_IRQFLAG);
  wire        wrPrioH = wrHit & (adr_ff == amc_pkg::OFS_PRIOHI);
  wire        wrPrioL = wrHit & (adr_ff == amc_pkg::OFS_PRIOLO);
  wire        wrPort  = wrHit & (adr_ff == amc_pkg::OFS_PORTDIR);
  wire        wrEvSt  = wrHit & (adr_ff == amc_pkg::OFS_EVSTAT);
  wire        wrEvMk  = wrHit & (adr_ff == amc_pkg::OFS_EVMASK);

  // Mode decode
  wire        swMode  = ~mode1_ff.trigMode[1];
  wire        hwWait  = mode1_ff.trigMode == amc_pkg::TRIG_HW_WAIT;
  wire        iss     = chan_ff[7];
  wire [4:0]  code    = chan_ff[4:0];
  wire [4:0]  curChan = mode0_ff.chanScan ? 5'(code + {3'h0, scanIdx_ff}) : code;
  wire        tempRef = iss & (curChan == amc_pkg::CH_TEMP) &
                        (mode2_ff.posRef == amc_pkg::REF_INTERNAL);
  // prohibited reference, prohibited speed, bad channel
  wire        badCfg  = (mode2_ff.posRef == amc_pkg::REF_BAD) | mode0_ff.speed[1] |
                        ~chanLegal(iss, curChan) | tempRef;

  wire [6:0]  ratio   = divRatio(mode0_ff.divSel);
  wire        divWrap = divCnt_ff >= 7'(ratio - 7'h01);
  wire [6:0]  nxt_divCnt = ~clkGateEn ? divCnt_ff : (divWrap ? 7'h00 : 7'(divCnt_ff + 7'h01));
  wire [4:0]  convLen = mode0_ff.speed[0] ? 5'(amc_pkg::CONV_TICKS_N2)
                                          : 5'(amc_pkg::CONV_TICKS_N1);

  wire        trigOk   = swMode | trigPend_ff;
  wire        canStart = (state_ff == amc_pkg::ST_IDLE) & mode0_ff.run &
                         mode0_ff.compEn & clkGateEn & trigOk;
  wire        startOk  = canStart & ~badCfg;
  wire        startBad = canStart & badCfg;
  wire        stopReq  = wrMode0 & ~wd[amc_pkg::RUN_BIT];
  wire        stabDone = (state_ff == amc_pkg::ST_STAB) & fadTick_ff &
                         (tickCnt_ff == 5'(STAB_TICKS_P - 1));
  wire        convDone = (state_ff == amc_pkg::ST_CONV) & fadTick_ff &
                         (tickCnt_ff == 5'(convLen - 5'h01));

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      amc_pkg::ST_IDLE: begin
        if (startOk) begin
          nxt_state = hwWait ? amc_pkg::ST_STAB : amc_pkg::ST_CONV;
        end
      end
      amc_pkg::ST_STAB: begin
        if (stabDone) begin
          nxt_state = amc_pkg::ST_CONV;
        end
      end
      amc_pkg::ST_CONV: begin
        if (convDone) begin
          nxt_state = amc_pkg::ST_IDLE;
        end
      end
      default: nxt_state = amc_pkg::ST_IDLE;
    endcase
    if (stopReq) begin
      nxt_state = amc_pkg::ST_IDLE;
    end
  end

  wire [4:0]  nxt_tickCnt = (nxt_state != state_ff || state_ff == amc_pkg::ST_IDLE) ? 5'h00 :
                            (fadTick_ff ? 5'(tickCnt_ff + 5'h01) : tickCnt_ff);

  // one-shot in software mode drops run
  wire        runDrop = swMode & ((convDone & mode1_ff.oneshot) | startBad);
  wire        nxt_run = wrMode0 ? wd[amc_pkg::RUN_BIT] : (mode0_ff.run & ~runDrop);
  // Trigger held until used; a late edge during a stop is dropped
  wire        nxt_trigPend = ~mode0_ff.run | stopReq | swMode ? 1'b0 :
                             ((hwTrigger & clkGateEn) | (trigPend_ff & ~canStart));
  wire [1:0]  nxt_scanIdx = (wrMode0 & wd[amc_pkg::RUN_BIT]) ? 2'h0 :
                            ((convDone & mode0_ff.chanScan) ? 2'(scanIdx_ff + 2'h1) : scanIdx_ff);

  // window test on upper result byte
  wire [7:0]  cmpVal  = analogSample[9:2];
  wire        inWin   = (lower_ff <= cmpVal) & (cmpVal <= upper_ff);
  wire        pass    = inWin ^ mode2_ff.limitMode;
  wire        setFlag = convDone & pass;
  wire [15:0] nxt_result = ~convDone ? result_ff :
                           (mode2_ff.res8 ? {analogSample[9:2], 8'h00} : {analogSample, 6'h00});
  // set wins over a software clear
  wire        nxt_irqFlag = setFlag | (wrFlag ? wd[0] : irqFlag_ff);
  wire [2:0]  evSet = {startBad, setFlag, convDone};
  wire [2:0]  nxt_evStat = evSet | (evStat_ff & ~(wrEvSt ? wd[2:0] : 3'h0));

  wire        runRead = hwWait ? (state_ff != amc_pkg::ST_IDLE) : mode0_ff.run;
  wire [7:0]  mode0Rd = {runRead, mode0_ff[6:0]};

  function automatic logic [31:0] readReg(input logic [7:0] a, input logic [7:0] m0);
    case (a)
      amc_pkg::OFS_MODE0:   readReg = {24'h0, m0};
      amc_pkg::OFS_MODE1:   readReg = {24'h0, mode1_ff};
      amc_pkg::OFS_MODE2:   readReg = {24'h0, mode2_ff};
      amc_pkg::OFS_UPPER:   readReg = {24'h0, upper_ff};
      amc_pkg::OFS_LOWER:   readReg = {24'h0, lower_ff};
      amc_pkg::OFS_CHAN:    readReg = {24'h0, chan_ff};
      amc_pkg::OFS_RESULT:  readReg = {16'h0, result_ff};
      amc_pkg::OFS_IRQMASK: readReg = {31'h0, irqMask_ff};
      amc_pkg::OFS_IRQFLAG: readReg = {31'h0, irqFlag_ff};
      amc_pkg::OFS_PRIOHI:  readReg = {31'h0, prioHi_ff};
      amc_pkg::OFS_PRIOLO:  readReg = {31'h0, prioLo_ff};
      amc_pkg::OFS_PORTDIR: readReg = {24'h0, portDir_ff};
      amc_pkg::OFS_EVSTAT:  readReg = {29'h0, evStat_ff};
      amc_pkg::OFS_EVMASK:  readReg = {29'h0, evMask_ff};
      default:              readReg = 32'h0;
    endcase
  endfunction

  wire [31:0] rdMux = readReg(adr_ff, mode0Rd);

  // Bus slave: one wait state avoids read-after-write hazards
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_ff   <= 1'b0;
      wr_ff     <= 1'b0;
      adr_ff    <= 8'h00;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0;
      hresp     <= 1'b0;
    end else begin
      pend_ff   <= addrPh;
      hreadyout <= ~addrPh;
      if (addrPh) begin
        wr_ff  <= hwrite;
        adr_ff <= haddr[7:0];
      end
      if (pend_ff) begin
        hrdata <= wr_ff ? 32'h0 : rdMux;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode0_ff <= amc_pkg::RST_MODE;
      mode1_ff <= amc_pkg::RST_MODE;
      mode2_ff <= amc_pkg::RST_MODE;
      upper_ff <= amc_pkg::RST_UPPER;
      lower_ff <= amc_pkg::RST_LOWER;
      chan_ff  <= amc_pkg::RST_MODE;
    end else begin
      mode0_ff.run <= nxt_run;
      if (wrMode0) mode0_ff[6:0] <= wd[6:0];
      if (wrMode1) mode1_ff <= wd & amc_pkg::WMASK_MODE1;
      if (wrMode2) mode2_ff <= wd & amc_pkg::WMASK_MODE2;
      if (wrUpper) upper_ff <= wd;
      if (wrLower) lower_ff <= wd;
      if (wrChan)  chan_ff  <= wd & amc_pkg::WMASK_CHAN;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqMask_ff <= 1'b1;
      irqFlag_ff <= 1'b0;
      prioHi_ff  <= 1'b1;
      prioLo_ff  <= 1'b1;
      portDir_ff <= amc_pkg::RST_PORTDIR;
      evStat_ff  <= 3'h0;
      evMask_ff  <= amc_pkg::RST_EVMASK;
    end else begin
      irqFlag_ff <= nxt_irqFlag;
      evStat_ff  <= nxt_evStat;
      if (wrMask)  irqMask_ff <= wd[0];
      if (wrPrioH) prioHi_ff  <= wd[0];
      if (wrPrioL) prioLo_ff  <= wd[0];
      if (wrPort)  portDir_ff <= wd;
      if (wrEvMk)  evMask_ff  <= wd[2:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff    <= amc_pkg::ST_IDLE;
      divCnt_ff   <= 7'h00;
      fadTick_ff  <= 1'b0;
      tickCnt_ff  <= 5'h00;
      trigPend_ff <= 1'b0;
      scanIdx_ff  <= 2'h0;
      result_ff   <= 16'h0;
    end else begin
      state_ff    <= nxt_state;
      divCnt_ff   <= nxt_divCnt;
      fadTick_ff  <= clkGateEn & divWrap;
      tickCnt_ff  <= nxt_tickCnt;
      trigPend_ff <= nxt_trigPend;
      scanIdx_ff  <= nxt_scanIdx;
      result_ff   <= nxt_result;
    end
  end

  // Registered outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      anaCtrl     <= '0;
      analogPinOe <= 1'b0;
      convEndIrq  <= 1'b0;
      irqPrio     <= 2'h3;
      irqOut      <= 1'b0;
    end else begin
      anaCtrl     <= {mode0_ff.compEn, mode2_ff.posRef, mode2_ff.negRef, iss, curChan,
                      mode2_ff.res8, state_ff == amc_pkg::ST_CONV};
      // buffer on only for direction zero
      analogPinOe <= ~portDir_ff[0];
      convEndIrq  <= irqFlag_ff & ~irqMask_ff;
      irqPrio     <= {prioHi_ff, prioLo_ff};
      irqOut      <= |(evStat_ff & ~evMask_ff);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence sAddr;
    addrPh;
  endsequence
  sequence sWaitThenReady;
    !hreadyout ##1 hreadyout;
  endsequence
  // Hardware start that skips the stabilization step
  sequence sNoWaitStart;
    startOk && !swMode && !hwWait && !stopReq;
  endsequence

  wire        idleNow = state_ff == amc_pkg::ST_IDLE;

  AST_BUS_WAIT: assert property (sAddr |=> sWaitThenReady)
    else $error("Bus access did not complete after one wait state");
  AST_FLAG_SET: assert property (setFlag |=> irqFlag_ff)
    else $error("Passing conversion did not set the request flag");
  AST_WINDOW_BLOCK: assert property (convDone && !pass && !irqFlag_ff && !wrFlag
                                     |=> !irqFlag_ff)
    else $error("Failing window check raised the request flag");
  AST_MASK_BLOCK: assert property (irqMask_ff [*2] |-> !convEndIrq)
    else $error("Masked request reached the interrupt output");
  AST_PIN_DIR: assert property (portDir_ff[0] [*2] |-> !analogPinOe)
    else $error("Output buffer on in input mode");
  AST_ONESHOT: assert property (convDone && swMode && mode1_ff.oneshot && !wrMode0
                                |=> !mode0_ff.run ##1 state_ff == amc_pkg::ST_IDLE)
    else $error("One-shot conversion did not stop");
  AST_NO_TEMP: assert property (idleNow ##1 !idleNow |-> !$past(tempRef))
    else $error("Temperature conversion started with internal reference");
  AST_RES8: assert property (convDone && mode2_ff.res8 |=> result_ff[7:0] == 8'h00)
    else $error("8-bit result not upper aligned");
  AST_DIV_GAP: assert property (fadTick_ff |=> !fadTick_ff)
    else $error("Conversion clock enable too fast");
  AST_WAIT_FIRST: assert property (startOk && hwWait && !stopReq
                                   |=> state_ff == amc_pkg::ST_STAB && runRead)
    else $error("Hardware wait mode skipped stabilization");
  AST_END_LOAD: assert property (convDone && !mode2_ff.res8
                                 |=> result_ff[15:6] == $past(analogSample))
    else $error("Result not loaded at conversion end");
  AST_STOP: assert property (stopReq |=> state_ff == amc_pkg::ST_IDLE)
    else $error("Writing run zero did not stop the converter");
  AST_NOWAIT_START: assert property (sNoWaitStart |=> state_ff == amc_pkg::ST_CONV)
    else $error("Hardware no-wait mode did not convert at once");
  AST_FLAG_CLEAR: assert property (wrFlag && !wd[0] && !setFlag |=> !irqFlag_ff)
    else $error("Writing zero did not clear the request flag");
  AST_PRIO_MAP: assert property (1'b1 |=> irqPrio == {$past(prioHi_ff), $past(prioLo_ff)})
    else $error("Priority output does not follow the priority bits");
  AST_EV_END: assert property (convDone |=> evStat_ff[amc_pkg::EV_END])
    else $error("Conversion end not recorded");
  AST_BAD_ERR: assert property (startBad |=> evStat_ff[amc_pkg::EV_ERR])
    else $error("Prohibited setting not reported");
  AST_BAD_STOP: assert property (startBad && swMode && !wrMode0
                                 |=> !mode0_ff.run)
    else $error("Prohibited setting left the run bit set");
  AST_OUT_COMP: assert property (1'b1 |=> anaCtrl.compEn == $past(mode0_ff.compEn))
    else $error("Comparator enable output does not follow the register");
  AST_OUT_NEGREF: assert property (1'b1 |=> anaCtrl.negRef == $past(mode2_ff.negRef))
    else $error("Negative reference output does not follow the register");
  AST_MASK_PASS: assert property (irqFlag_ff && !irqMask_ff |=> convEndIrq)
    else $error("Unmasked request did not reach the interrupt output");
  AST_PIN_OUT: assert property (!portDir_ff[0] |=> analogPinOe)
    else $error("Output buffer off in output mode");
  AST_RES10: assert property (convDone && !mode2_ff.res8 |=> result_ff[5:0] == 6'h00)
    else $error("10-bit result not upper aligned");
endmodule

// file: amc_adc_mode_ctrl_tb.sv
// Purpose: self-checking bench for the converter mode control block
// Assumes: single AHB-Lite master in this bench, whole-word single transfers
// Notes: short stabilization parameter keeps hardware-wait conversions brief
`timescale 1ns/1ns
module amc_adc_mode_ctrl_tb;
  localparam int STAB = 1;
  localparam logic [7:0] OFS [15] = '{amc_pkg::OFS_MODE0, amc_pkg::OFS_MODE1,
    amc_pkg::OFS_MODE2, amc_pkg::OFS_UPPER, amc_pkg::OFS_LOWER, amc_pkg::OFS_CHAN,
    amc_pkg::OFS_RESULT, amc_pkg::OFS_IRQMASK, amc_pkg::OFS_IRQFLAG, amc_pkg::OFS_PRIOHI,
    amc_pkg::OFS_PRIOLO, amc_pkg::OFS_PORTDIR, amc_pkg::OFS_EVSTAT, amc_pkg::OFS_EVMASK,
    8'h3C};
  localparam logic [7:0] RSTV [15] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00,
    8'h01, 8'h00, 8'h01, 8'h01, 8'hFF, 8'h00, 8'h07, 8'h00};
  // Result, status and the unmapped word keep reading zero after writes
  localparam logic [7:0] WMSK [15] = '{8'hFF, 8'hE3, 8'hED, 8'hFF, 8'hFF, 8'h9F, 8'h00,
    8'h01, 8'h01, 8'h01, 8'h01, 8'hFF, 8'h00, 8'h07, 8'h00};
  localparam int RATIO [8] = '{64, 32, 16, 8, 6, 5, 4, 2};

  logic              clk;
  logic              sys_rst;
  logic              hsel;
  logic [31:0]       haddr;
  logic [1:0]        htrans;
  logic              hwrite;
  logic [2:0]        hsize;
  logic [31:0]       hwdata;
  wire logic         hready;
  logic              hreadyout;
  logic [31:0]       hrdata;
  logic              hresp;
  logic              clkGateEn;
  logic              hwTrigger;
  logic [9:0]        analogSample;
  amc_pkg::amc_ana_s anaCtrl;
  logic              analogPinOe;
  logic              convEndIrq;
  logic [1:0]        irqPrio;
  logic              irqOut;
  int                failures;
  int                samples_checked;
  int                n;
  int                tk;
  logic [31:0]       rdv;
  logic [7:0]        shadow [15];
  logic [7:0]        wd;
  logic [7:0]        lo;
  logic [7:0]        hi;
  logic [9:0]        smp;
  logic              lim;
  logic              res;
  logic              spd;
  logic              msk;
  logic              hw;
  logic              scn;
  logic              pass;

  assign hready = hreadyout;

  amc_adc_mode_ctrl #(.STAB_TICKS_P(STAB)) i_dut (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .hsel         (hsel),
    .haddr        (haddr),
    .htrans       (htrans),
    .hwrite       (hwrite),
    .hsize        (hsize),
    .hwdata       (hwdata),
    .hready       (hready),
    .hreadyout    (hreadyout),
    .hrdata       (hrdata),
    .hresp        (hresp),
    .clkGateEn    (clkGateEn),
    .hwTrigger    (hwTrigger),
    .analogSample (analogSample),
    .anaCtrl      (anaCtrl),
    .analogPinOe  (analogPinOe),
    .convEndIrq   (convEndIrq),
    .irqPrio      (irqPrio),
    .irqOut       (irqOut)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tally_and_finish;
    if (failures == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // A bounded wait that runs out is reported as a mismatch
  task automatic hang;
    chk(32'hDEAD, 32'h0);
    tally_and_finish();
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    int k;
    k = 0;
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 100);
    rd = hrdata;
    if (k >= 100) hang();
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h000000, d}, rdv);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, rdv);
    chk(rdv, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic waitIrq(input int limit);
    n = 0;
    while (irqOut !== 1'b1 && n < limit) begin
      @(posedge clk);
      n++;
    end
    if (n >= limit) hang();
  endtask

  function automatic logic [31:0] expOut();
    return {15'h0, shadow[0][0], shadow[2][7:6], shadow[2][5], shadow[5][7], shadow[5][4:0],
            shadow[2][0], 1'b0, shadow[9][0], shadow[10][0], ~shadow[11][0],
            shadow[8][0] & ~shadow[7][0], 1'b0};
  endfunction

  function automatic logic winPass(logic [7:0] v, logic [7:0] l, logic [7:0] h, logic m);
    return m ? (v < l || v > h) : (v >= l && v <= h);
  endfunction

  initial begin
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    clkGateEn = 1'b1;
    hwTrigger = 1'b0;
    analogSample = 10'h000;
    failures = 0;
    samples_checked = 0;
    void'($urandom(67));
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 15; i++) begin
      rc(OFS[i], {24'h0, RSTV[i]});
      shadow[i] = RSTV[i];
    end
    chk({15'h0, anaCtrl, irqPrio, analogPinOe, convEndIrq, irqOut}, expOut());
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < 15; i++) begin
        wd = 8'($urandom);
        if (i == 0) wd[7] = 1'b0;
        if (i == 2) begin
          shadow[0][0] = 1'b0;
          wr(amc_pkg::OFS_MODE0, shadow[0]);
          wr(amc_pkg::OFS_MODE2, 8'h00);
        end
        wr(OFS[i], wd);
        if (WMSK[i] != 8'h00) shadow[i] = wd & WMSK[i];
        rc(OFS[i], {24'h0, shadow[i]});
        chk({15'h0, anaCtrl, irqPrio, analogPinOe, convEndIrq, irqOut}, expOut());
      end
    end
    for (int p = 0; p < 4; p++) begin
      wr(amc_pkg::OFS_PRIOHI, {7'h0, p[1]});
      wr(amc_pkg::OFS_PRIOLO, {7'h0, p[0]});
      @(posedge clk);
      chk({30'h0, irqPrio}, p);
    end
    // Writes while the clock supply is off must not land
    clkGateEn <= 1'b0;
    wr(amc_pkg::OFS_UPPER, ~shadow[3]);
    clkGateEn <= 1'b1;
    rc(amc_pkg::OFS_UPPER, {24'h0, shadow[3]});
    for (int i = 0; i < 8; i++) begin
      smp = 10'($urandom);
      lo = 8'($urandom);
      hi = 8'($urandom);
      lim = 1'($urandom);
      res = 1'($urandom);
      spd = 1'($urandom);
      msk = i[0];
      hw = (i == 2 || i == 4);
      scn = (i == 3);
      if (i < 2) begin
        lo = smp[9:2];
        hi = smp[9:2];
        lim = i[0];
      end
      pass = winPass(smp[9:2], lo, hi, lim);
      analogSample <= smp;
      wr(amc_pkg::OFS_MODE1, hw ? (i == 2 ? 8'hE0 : 8'hA0) : (i == 7 ? 8'h00 : 8'h20));
      wr(amc_pkg::OFS_MODE2, {4'h0, lim, 2'h0, res});
      wr(amc_pkg::OFS_LOWER, lo);
      wr(amc_pkg::OFS_UPPER, hi);
      wr(amc_pkg::OFS_CHAN, 8'h03);
      wr(amc_pkg::OFS_IRQMASK, {7'h0, msk});
      wr(amc_pkg::OFS_IRQFLAG, 8'h00);
      wr(amc_pkg::OFS_EVMASK, 8'h06);
      wr(amc_pkg::OFS_EVSTAT, 8'h07);
      wr(amc_pkg::OFS_MODE0, {1'b1, scn, i[2:0], 1'b0, spd, 1'b1});
      if (hw) begin
        rc(amc_pkg::OFS_MODE0, {24'h0, i == 4, 1'b0, i[2:0], 1'b0, spd, 1'b1});
        hwTrigger <= 1'b1;
        @(posedge clk);
        hwTrigger <= 1'b0;
      end else begin
        repeat (2) @(posedge clk);
        chk({31'h0, anaCtrl.converting}, 32'h1);
      end
      waitIrq(3000);
      tk = (spd ? 17 : 19) + (i == 2 ? STAB : 0);
      chk({31'h0, n >= (tk - 1) * RATIO[i] && n <= (tk + 1) * RATIO[i] + 8}, 32'h1);
      rc(amc_pkg::OFS_RESULT, res ? {16'h0, smp[9:2], 8'h00} : {16'h0, smp, 6'h00});
      rc(amc_pkg::OFS_IRQFLAG, {31'h0, pass});
      chk({31'h0, convEndIrq}, {31'h0, pass & ~msk});
      chk({27'h0, anaCtrl.chan}, scn ? 32'h4 : 32'h3);
      rc(amc_pkg::OFS_MODE0, {24'h0, i == 7 || i == 4, scn, i[2:0], 1'b0, spd, 1'b1});
      wr(amc_pkg::OFS_MODE0, 8'h00);
      wr(amc_pkg::OFS_IRQFLAG, 8'h00);
      rc(amc_pkg::OFS_IRQFLAG, 32'h0);
    end
    // Reserved reference code, then temperature channel on internal reference
    for (int j = 0; j < 2; j++) begin
      wr(amc_pkg::OFS_MODE0, 8'h00);
      wr(amc_pkg::OFS_MODE2, 8'h00);
      wr(amc_pkg::OFS_MODE2, j ? 8'h80 : 8'hC0);
      wr(amc_pkg::OFS_CHAN, j ? 8'h80 : 8'h03);
      wr(amc_pkg::OFS_MODE1, 8'h00);
      wr(amc_pkg::OFS_EVMASK, 8'h03);
      wr(amc_pkg::OFS_EVSTAT, 8'h07);
      wr(amc_pkg::OFS_MODE0, 8'h01);
      wr(amc_pkg::OFS_MODE0, 8'h81);
      waitIrq(50);
      rc(amc_pkg::OFS_EVSTAT, 32'h4);
      rc(amc_pkg::OFS_MODE0, 32'h1);
      wr(amc_pkg::OFS_EVSTAT, 8'h04);
      rc(amc_pkg::OFS_EVSTAT, 32'h0);
      chk({31'h0, irqOut}, 32'h0);
    end
    tally_and_finish();
  end
endmodule
